// >>> design/fps_pkg.sv
// Package: register map, field layout, reset values for presence and click logic
package fps_pkg;
  localparam logic [7:0] FPS_QPT_OFFSET = 8'h78;
  localparam logic [7:0] FPS_REFL_OFFSET = 8'h79;
  localparam logic [7:0] FPS_PSTAT_OFFSET = 8'h7a;
  localparam logic [7:0] FPS_SCCTL_OFFSET = 8'h7b;
  localparam logic [7:0] FPS_HOLD_OFFSET = 8'h7c;
  localparam logic [7:0] FPS_DBL_OFFSET = 8'h7d;
  localparam logic [7:0] FPS_MLIM_OFFSET = 8'h7e;
  localparam logic [7:0] FPS_FLAGS_OFFSET = 8'h7f;
  localparam logic [7:0] FPS_QPT_RESET = 8'h40;
  localparam logic [7:0] FPS_REFL_RESET = 8'h00;
  localparam logic [7:0] FPS_PSTAT_RESET = 8'h00;
  localparam logic [7:0] FPS_SCCTL_RESET = 8'h25;
  localparam logic [7:0] FPS_HOLD_RESET = 8'h45;
  localparam logic [7:0] FPS_DBL_RESET = 8'h1e;
  localparam logic [7:0] FPS_MLIM_RESET = 8'h19;
  localparam logic [7:0] FPS_FLAGS_RESET = 8'h00;
  localparam int FPS_SINGLE_BIT = 0;
  localparam int FPS_DOUBLE_BIT = 1;
  localparam int FPS_HOLD_BIT = 2;
  localparam int FPS_PRESENT_BIT = 0;
  localparam int FPS_HYST_LSB = 4;
  localparam int FPS_QHYST_LSB = 1;
  localparam int FPS_TIMRES_LSB = 4;
  localparam int FPS_HYST_SCALE = 8;
  localparam int FPS_QHYST_SCALE = 4;
  // Gesture timers count in ticks of this many clocks
  localparam int FPS_TICK_CYCLES = 1250;
  localparam logic [7:0] FPS_PSTAT_WMASK = 8'hfe;
  localparam logic [7:0] FPS_SCCTL_WMASK = 8'h77;
  localparam logic [7:0] FPS_FLAGS_WMASK = 8'h07;
endpackage : fps_pkg

// >>> design/fps_presence.sv
// Finger presence decision with hysteresis on reflectivity and quality
`timescale 1ns/1ps
`default_nettype none
module fps_presence (
  input wire logic CLK_IN, // Clock
  input wire logic SRST_IN, // Sync reset
  input wire logic sample_in, // New frame sample
  input wire logic [7:0] refl_in, // Reflectivity value
  input wire logic [7:0] qual_in, // Surface quality
  input wire logic [7:0] refl_thr_in, // Reflectivity threshold
  input wire logic [7:0] qual_thr_in, // Quality threshold
  input wire logic qual_en_in, // Quality presence enable
  input wire logic [3:0] hyst_in, // Hysteresis boundary
  input wire logic [2:0] qhyst_in, // Quality hysteresis boundary
  output logic present_out // Finger present
);
  import fps_pkg::*;
  logic present_q;
  logic present_d;
  wire [8:0] hyst_w = 9'(FPS_HYST_SCALE * hyst_in);
  wire [8:0] qhyst_w = 9'(FPS_QHYST_SCALE * qhyst_in);
  wire refl_on = {1'b0, refl_in} >= {1'b0, refl_thr_in} + hyst_w;
  wire refl_off = {1'b0, refl_in} + hyst_w < {1'b0, refl_thr_in};
  wire qual_on = {1'b0, qual_in} >= {1'b0, qual_thr_in} + qhyst_w;
  wire qual_off = {1'b0, qual_in} + qhyst_w < {1'b0, qual_thr_in};
  wire on_w = refl_on | (qual_en_in & qual_on);
  wire off_w = refl_off & (~qual_en_in | qual_off);
  always_comb begin
    present_d = present_q;
    if (sample_in && on_w) begin
      present_d = 1'b1;
    end else if (sample_in && off_w) begin
      present_d = 1'b0;
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      present_q <= 1'b0;
    end else begin
      present_q <= present_d;
    end
  end
  assign present_out = present_q;
endmodule : fps_presence
`default_nettype wire

// >>> design/fps_tick.sv
// Free-running tick generator for gesture timers
`timescale 1ns/1ps
`default_nettype none
module fps_tick #(
  parameter int TICK_CYCLES = 1250
) (
  input wire logic CLK_IN, // Clock
  input wire logic SRST_IN, // Sync reset
  output logic tick_out // One-cycle tick
);
  logic [15:0] cnt_q;
  logic tick_q;
  wire wrap_w = cnt_q == 16'(TICK_CYCLES - 1);
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= wrap_w ? 16'h0000 : cnt_q + 16'h0001;
      tick_q <= wrap_w;
    end
  end
  assign tick_out = tick_q;
endmodule : fps_tick
`default_nettype wire

// >>> design/fps_regs.sv
// Presence and soft-click register bank with gesture recognizer
// Overview of operation
// - Quality threshold comparison used only when quality presence enable set.
// - Hold eight-bit reflectivity value; larger means more reflective.
// - Presence hysteresis equals eight times status bits 7:4.
// - Quality hysteresis equals four times status bits 3:1.
// - Status bit 0 shows finger present.
// - Hold timer resets per three-bit threshold in control bits 6:4.
// - Single, double, hold detection gated by control bits 0,1,2.
// - Wait at least programmed delay before signalling tap-and-hold.
// - Second click within programmed window becomes double click.
// - Single click valid only if X plus Y motion below limit.
// - Record gesture on soft-click event; host reads flags register.
// - Flags: bit 2 hold, bit 1 double, bit 0 single.
`timescale 1ns/1ps
`default_nettype none
module fps_regs #(
  parameter int TICK_CYCLES = fps_pkg::FPS_TICK_CYCLES
) (
  input wire logic CLK_IN, // 125 MHz clock
  input wire logic SRST_IN, // Sync reset, active high
  input wire logic REG_WR_IN, // Register write strobe
  input wire logic REG_RD_IN, // Register read strobe
  input wire logic [7:0] REG_ADDR_IN, // Register address
  input wire logic [7:0] REG_WDATA_IN, // Write data
  output logic [7:0] REG_RDATA_OUT, // Read data, registered
  input wire logic QUAL_EN_IN, // Quality presence enable from engine config
  input wire logic FRAME_IN, // Frame done pulse
  input wire logic [7:0] REFL_IN, // Measured reflectivity
  input wire logic [7:0] QUAL_IN, // Surface quality
  input wire logic [7:0] REFL_THR_IN, // Reflectivity threshold
  input wire logic [7:0] DELTA_X_IN, // Motion X magnitude
  input wire logic [7:0] DELTA_Y_IN, // Motion Y magnitude
  output logic PRESENT_OUT, // Finger present
  output logic CLICK_EVENT_OUT // Soft-click event pulse
);
  import fps_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE, ST_TOUCH, ST_WAIT2, ST_TOUCH2, ST_HELD
  } fps_state_type;
  fps_state_type state_q;
  fps_state_type state_d;
  logic [7:0] qpt_q;
  logic [7:0] refl_q;
  logic [7:0] pstat_q;
  logic [7:0] scctl_q;
  logic [7:0] hold_q;
  logic [7:0] dbl_q;
  logic [7:0] mlim_q;
  logic [7:0] flags_q;
  logic [7:0] rdata_q;
  logic [7:0] timer_q;
  logic [2:0] still_q;
  logic [8:0] motion_q;
  logic evt_q;
  logic [2:0] set_d;
  logic tick;
  logic present;
  logic frame_s1_q;
  logic frame_s2_q;
  logic frame_s3_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return REG_WR_IN && a == off;
  endfunction

  fps_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .CLK_IN(CLK_IN),
    .SRST_IN(SRST_IN),
    .tick_out(tick)
  );

  // Frame pulse comes from the imaging side; resynchronise
  wire frame_w = frame_s2_q & ~frame_s3_q;

  fps_presence u_presence (
    .CLK_IN(CLK_IN),
    .SRST_IN(SRST_IN),
    .sample_in(frame_w),
    .refl_in(REFL_IN),
    .qual_in(QUAL_IN),
    .refl_thr_in(REFL_THR_IN),
    .qual_thr_in(qpt_q),
    .qual_en_in(QUAL_EN_IN),
    .hyst_in(pstat_q[7:FPS_HYST_LSB]),
    .qhyst_in(pstat_q[3:FPS_QHYST_LSB]),
    .present_out(present)
  );

  wire en_single = scctl_q[FPS_SINGLE_BIT];
  wire en_double = scctl_q[FPS_DOUBLE_BIT];
  wire en_hold = scctl_q[FPS_HOLD_BIT];
  wire [2:0] timres_w = scctl_q[6:FPS_TIMRES_LSB];
  wire [8:0] frame_sum_w = {1'b0, DELTA_X_IN} + {1'b0, DELTA_Y_IN};
  // Sum kept one bit wider so saturation sees the true total
  wire [9:0] motion_raw_w = {1'b0, motion_q} + {1'b0, frame_sum_w};
  wire [8:0] motion_sum_w = (motion_raw_w > 10'h0ff) ? 9'h0ff : motion_raw_w[8:0];
  wire still_ok = motion_q < {1'b0, mlim_q};
  wire timer_sat = timer_q == 8'hff;
  wire released = ~present;

  always_comb begin
    state_d = state_q;
    set_d = 3'h0;
    case (state_q)
      ST_IDLE: begin
        if (present) begin
          state_d = ST_TOUCH;
        end
      end
      ST_TOUCH: begin
        if (en_hold && timer_q >= hold_q && still_q <= timres_w) begin
          set_d[FPS_HOLD_BIT] = 1'b1;
          state_d = ST_HELD;
        end else if (released) begin
          if (!still_ok) begin
            state_d = ST_IDLE;
          end else if (en_double) begin
            state_d = ST_WAIT2;
          end else begin
            set_d[FPS_SINGLE_BIT] = en_single;
            state_d = ST_IDLE;
          end
        end
      end
      ST_WAIT2: begin
        if (present && timer_q < dbl_q) begin
          state_d = ST_TOUCH2;
        end else if (timer_q >= dbl_q) begin
          set_d[FPS_SINGLE_BIT] = en_single;
          state_d = ST_IDLE;
        end
      end
      ST_TOUCH2: begin
        if (released) begin
          set_d[FPS_DOUBLE_BIT] = still_ok;
          state_d = ST_IDLE;
        end
      end
      ST_HELD: begin
        if (released) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  wire state_change = state_d != state_q;

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      frame_s1_q <= 1'b0;
      frame_s2_q <= 1'b0;
      frame_s3_q <= 1'b0;
    end else begin
      frame_s1_q <= FRAME_IN;
      frame_s2_q <= frame_s1_q;
      frame_s3_q <= frame_s2_q;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state_q <= ST_IDLE;
      timer_q <= 8'h00;
      still_q <= 3'h0;
      motion_q <= 9'h000;
    end else begin
      state_q <= state_d;
      if (state_change) begin
        timer_q <= 8'h00;
      end else if (tick && !timer_sat) begin
        timer_q <= timer_q + 8'h01;
      end
      if (state_change || (frame_w && frame_sum_w == 9'h000)) begin
        still_q <= 3'h0;
      end else if (frame_w && still_q != 3'h7) begin
        still_q <= still_q + 3'h1;
      end
      if (state_d == ST_TOUCH && state_q != ST_TOUCH) begin
        motion_q <= 9'h000;
      end else if (frame_w) begin
        motion_q <= motion_sum_w;
      end
      if (state_q == ST_TOUCH && still_q > timres_w && frame_w && frame_sum_w != 9'h000) begin
        timer_q <= 8'h00;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      refl_q <= FPS_REFL_RESET;
    end else if (hit(REG_ADDR_IN, FPS_REFL_OFFSET)) begin
      refl_q <= REG_WDATA_IN;
    end else if (frame_w) begin
      refl_q <= REFL_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      qpt_q <= FPS_QPT_RESET;
      pstat_q <= FPS_PSTAT_RESET;
      scctl_q <= FPS_SCCTL_RESET;
      hold_q <= FPS_HOLD_RESET;
      dbl_q <= FPS_DBL_RESET;
      mlim_q <= FPS_MLIM_RESET;
    end else begin
      if (hit(REG_ADDR_IN, FPS_QPT_OFFSET)) begin
        qpt_q <= REG_WDATA_IN;
      end
      pstat_q[FPS_PRESENT_BIT] <= present;
      if (hit(REG_ADDR_IN, FPS_PSTAT_OFFSET)) begin
        pstat_q[7:1] <= REG_WDATA_IN[7:1] & FPS_PSTAT_WMASK[7:1];
      end
      if (hit(REG_ADDR_IN, FPS_SCCTL_OFFSET)) begin
        scctl_q <= REG_WDATA_IN & FPS_SCCTL_WMASK;
      end
      if (hit(REG_ADDR_IN, FPS_HOLD_OFFSET)) begin
        hold_q <= REG_WDATA_IN;
      end
      if (hit(REG_ADDR_IN, FPS_DBL_OFFSET)) begin
        dbl_q <= REG_WDATA_IN;
      end
      if (hit(REG_ADDR_IN, FPS_MLIM_OFFSET)) begin
        mlim_q <= REG_WDATA_IN;
      end
    end
  end

  // host writes zero, new event wins
  wire [7:0] flags_keep = hit(REG_ADDR_IN, FPS_FLAGS_OFFSET) ?
    (flags_q & REG_WDATA_IN & FPS_FLAGS_WMASK) : flags_q;

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      flags_q <= FPS_FLAGS_RESET;
      evt_q <= 1'b0;
    end else begin
      flags_q <= flags_keep | {5'h00, set_d};
      evt_q <= |set_d;
    end
  end

  always_comb begin
    case (REG_ADDR_IN)
      FPS_QPT_OFFSET: REG_RDATA_OUT = 8'h00;
      default: REG_RDATA_OUT = 8'h00;
    endcase
    REG_RDATA_OUT = rdata_q;
  end

  wire [7:0] rd_mux =
    (REG_ADDR_IN == FPS_QPT_OFFSET) ? qpt_q :
    (REG_ADDR_IN == FPS_REFL_OFFSET) ? refl_q :
    (REG_ADDR_IN == FPS_PSTAT_OFFSET) ? pstat_q :
    (REG_ADDR_IN == FPS_SCCTL_OFFSET) ? scctl_q :
    (REG_ADDR_IN == FPS_HOLD_OFFSET) ? hold_q :
    (REG_ADDR_IN == FPS_DBL_OFFSET) ? dbl_q :
    (REG_ADDR_IN == FPS_MLIM_OFFSET) ? mlim_q :
    (REG_ADDR_IN == FPS_FLAGS_OFFSET) ? flags_q : 8'h00;

  // Read data held until next read so the serial side can shift it out
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      rdata_q <= 8'h00;
    end else if (REG_RD_IN) begin
      rdata_q <= rd_mux;
    end
  end

  assign PRESENT_OUT = pstat_q[FPS_PRESENT_BIT];
  assign CLICK_EVENT_OUT = evt_q;
endmodule : fps_regs
`default_nettype wire

// >>> testbench/fps_regs_chk.sv
// Checker: port-level behaviour of the presence and click register bank
`timescale 1ns/1ps
`default_nettype none
module fps_regs_chk
  import fps_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic CLK_IN, // Clock
  input wire logic SRST_IN, // Reset
  input wire logic REG_WR_IN, // Write strobe
  input wire logic REG_RD_IN, // Read strobe
  input wire logic [7:0] REG_ADDR_IN, // Address
  input wire logic [7:0] REG_WDATA_IN, // Write data
  input wire logic [7:0] REG_RDATA_OUT, // Read data
  input wire logic QUAL_EN_IN, // Quality enable
  input wire logic FRAME_IN, // Frame done
  input wire logic [7:0] REFL_IN, // Reflectivity
  input wire logic [7:0] QUAL_IN, // Quality
  input wire logic [7:0] REFL_THR_IN, // Threshold
  input wire logic [7:0] DELTA_X_IN, // Motion X
  input wire logic [7:0] DELTA_Y_IN, // Motion Y
  input wire logic PRESENT_OUT, // Present
  input wire logic CLICK_EVENT_OUT // Click event
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  logic [3:0] since_frame_q;
  // Saturates so long idle spans cannot wrap
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || $rose(FRAME_IN)) since_frame_q <= 4'h0;
    else if (since_frame_q != 4'hf) since_frame_q <= since_frame_q + 4'h1;
  end
  property p_readback(logic [7:0] a);
    (REG_WR_IN && REG_ADDR_IN == a) ##2 (REG_RD_IN && REG_ADDR_IN == a)
      |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 3);
  endproperty
  AST_RDATA_HOLDS: assert property (!$past(REG_RD_IN) |-> $stable(REG_RDATA_OUT))
    else $error("read data moved without a read");
  AST_EVENT_PULSE: assert property (CLICK_EVENT_OUT |=> !CLICK_EVENT_OUT)
    else $error("click event longer than one cycle");
  AST_CTL_RSVD: assert property (REG_RD_IN && REG_ADDR_IN == FPS_SCCTL_OFFSET
    |=> (REG_RDATA_OUT & 8'h88) == 8'h00) else $error("control reserved bits set");
  AST_FLAGS_RSVD: assert property (REG_RD_IN && REG_ADDR_IN == FPS_FLAGS_OFFSET
    |=> REG_RDATA_OUT[7:3] == 5'h00) else $error("flag reserved bits set");
  AST_UNMAPPED: assert property (REG_RD_IN && REG_ADDR_IN < FPS_QPT_OFFSET
    |=> REG_RDATA_OUT == 8'h00) else $error("unmapped read not zero");
  AST_PRESENT_AFTER_FRAME: assert property ($changed(PRESENT_OUT) |-> since_frame_q <= 4'h8)
    else $error("presence changed without a frame");
  AST_STATUS_BIT: assert property ((REG_RD_IN && REG_ADDR_IN == FPS_PSTAT_OFFSET
    && $stable(PRESENT_OUT)) ##1 $stable(PRESENT_OUT) |-> REG_RDATA_OUT[0] == PRESENT_OUT)
    else $error("status bit differs from presence");
  AST_HOLD_RB: assert property (p_readback(FPS_HOLD_OFFSET))
    else $error("hold delay readback wrong");
  AST_DBL_RB: assert property (p_readback(FPS_DBL_OFFSET))
    else $error("double window readback wrong");
  AST_MLIM_RB: assert property (p_readback(FPS_MLIM_OFFSET))
    else $error("motion limit readback wrong");
  COV_EVENT: cover property (CLICK_EVENT_OUT);
  COV_PRESENT: cover property ($rose(PRESENT_OUT));
  COV_FLAGS_RD: cover property (REG_RD_IN && REG_ADDR_IN == FPS_FLAGS_OFFSET);
endmodule // fps_regs_chk
`default_nettype wire

// >>> testbench/fps_host.sv
// Host model: register writes and reads over the strobe port
`timescale 1ns/1ps
`default_nettype none
module fps_host (
  input wire logic clk_in, // Clock
  output logic wr_out, // Write strobe
  output logic rd_out, // Read strobe
  output logic [7:0] addr_out, // Address
  output logic [7:0] wdata_out, // Write data
  input wire logic [7:0] rdata_in // Read data
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    // Released bus must not look valid
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask
endmodule // fps_host
`default_nettype wire

// >>> testbench/test_fps_regs.sv
// Testbench: register map, presence hysteresis and soft-click gestures
`timescale 1ns/1ps
`default_nettype none
module test_fps_regs;
  import fps_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr, rd, frame, pres, ev;
  logic [7:0] addr, wdata, rdata, got;
  logic [7:0] refl = 8'h00;
  logic qen = 1'b0;
  logic [7:0] dx = 8'h00;
  logic [7:0] dy = 8'h00;
  int mismatches = 0;
  int cmp_count = 0;
  int ev_count = 0;
  int n;
  logic [7:0] rst_v [8] = '{8'h40, 8'h00, 8'h00, 8'h25, 8'h45, 8'h1e, 8'h19, 8'h00};
  logic [7:0] msk_v [7] = '{8'hff, 8'hff, 8'hfe, 8'h77, 8'hff, 8'hff, 8'hff};
  logic [7:0] g_ctl [6] = '{8'h01, 8'h01, 8'h00, 8'h03, 8'h03, 8'h04};
  logic [7:0] g_d [6] = '{8'h01, 8'h10, 8'h01, 8'h01, 8'h01, 8'h00};
  logic [7:0] g_exp [6] = '{8'h01, 8'h00, 8'h00, 8'h02, 8'h01, 8'h04};
  int g_touch [6] = '{2, 2, 2, 2, 2, 6};
  int g_clicks [6] = '{1, 1, 1, 2, 1, 1};
  initial frame = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) if (ev === 1'b1) ev_count <= ev_count + 1;
  // Short tick keeps gesture windows within a brief run
  fps_regs #(.TICK_CYCLES(4)) i_dut (
    .CLK_IN(clk), .SRST_IN(srst), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .QUAL_EN_IN(qen), .FRAME_IN(frame),
    .REFL_IN(refl), .QUAL_IN(8'h80), .REFL_THR_IN(8'h40), .DELTA_X_IN(dx),
    .DELTA_Y_IN(dy), .PRESENT_OUT(pres), .CLICK_EVENT_OUT(ev)
  );
  fps_host u_host (
    .clk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata),
    .rdata_in(rdata)
  );
  task automatic check(input logic [7:0] id, input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: item %h got %h expected %h", $time, id, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, got);
    check(a, got, e);
  endtask
  task automatic frm(input logic [7:0] r, input logic [7:0] d);
    @(posedge clk);
    #1;
    refl = r;
    dx = d;
    dy = d;
    frame = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    frame = 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    for (int i = 0; i < 8; i++) rchk(8'h78 + 8'(i), rst_v[i]);
    u_host.wr(8'h61, 8'h5a);
    rchk(8'h61, 8'h00);
    for (int i = 0; i < 7; i++) begin
      u_host.wr(8'h78 + 8'(i), 8'hff);
      rchk(8'h78 + 8'(i), msk_v[i]);
      u_host.wr(8'h78 + 8'(i), rst_v[i]);
    end
    u_host.wr(FPS_PSTAT_OFFSET, 8'h10);
    frm(8'h47, 8'h00);
    check(8'hf0, {7'h00, pres}, 8'h00);
    frm(8'h48, 8'h00);
    check(8'hf1, {7'h00, pres}, 8'h01);
    rchk(FPS_PSTAT_OFFSET, 8'h11);
    rchk(FPS_REFL_OFFSET, 8'h48);
    frm(8'h39, 8'h00);
    check(8'hf2, {7'h00, pres}, 8'h01);
    frm(8'h37, 8'h00);
    check(8'hf3, {7'h00, pres}, 8'h00);
    #1;
    qen = 1'b1;
    frm(8'h00, 8'h00);
    check(8'hf4, {7'h00, pres}, 8'h01);
    #1;
    qen = 1'b0;
    frm(8'h00, 8'h00);
    check(8'hf5, {7'h00, pres}, 8'h00);
    // Touches above leave flags behind; start gestures clean
    u_host.wr(FPS_FLAGS_OFFSET, 8'h00);
    rchk(FPS_FLAGS_OFFSET, 8'h00);
    u_host.wr(FPS_HOLD_OFFSET, 8'h02);
    for (int i = 0; i < 6; i++) begin
      n = ev_count;
      u_host.wr(FPS_SCCTL_OFFSET, g_ctl[i]);
      repeat (g_clicks[i]) begin
        repeat (g_touch[i]) frm(8'h80, g_d[i]);
        frm(8'h00, 8'h00);
      end
      repeat (200) @(posedge clk);
      rchk(FPS_FLAGS_OFFSET, g_exp[i]);
      check(8'hee, 8'(ev_count - n), {7'h00, g_exp[i] != 8'h00});
      repeat (20) @(posedge clk);
      rchk(FPS_FLAGS_OFFSET, g_exp[i]);
      u_host.wr(FPS_FLAGS_OFFSET, 8'h00);
      rchk(FPS_FLAGS_OFFSET, 8'h00);
    end
    end_of_test();
  end
endmodule // test_fps_regs
bind fps_regs fps_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .QUAL_EN_IN(QUAL_EN_IN), .FRAME_IN(FRAME_IN), .REFL_IN(REFL_IN), .QUAL_IN(QUAL_IN),
  .REFL_THR_IN(REFL_THR_IN), .DELTA_X_IN(DELTA_X_IN), .DELTA_Y_IN(DELTA_Y_IN),
  .PRESENT_OUT(PRESENT_OUT), .CLICK_EVENT_OUT(CLICK_EVENT_OUT)
);
`default_nettype wire
